/* File: inc/isc_pkg.sv */
// Package for the I2C interrupt status, threshold and clear block
`default_nettype none
package isc_pkg;

	// Register byte offsets
	localparam logic [7:0] OFF_RX_THRESHOLD = 8'h38;
	localparam logic [7:0] OFF_TX_THRESHOLD = 8'h3C;
	localparam logic [7:0] OFF_COMBINED_CLEAR = 8'h40;
	localparam logic [7:0] OFF_RX_UNDERFLOW_CLEAR = 8'h44;
	localparam logic [7:0] OFF_RX_OVERFLOW_CLEAR = 8'h48;
	localparam logic [7:0] OFF_TX_OVERFLOW_CLEAR = 8'h4C;
	// Offsets chosen for registers with no printed address
	localparam logic [7:0] OFF_RAW_STATUS = 8'h34;
	localparam logic [7:0] OFF_OPTIONS = 8'h70;

	// Raw status bit positions
	localparam int BIT_RX_UNDERFLOW = 0;
	localparam int BIT_RX_OVERFLOW = 1;
	localparam int BIT_RX_FULL = 2;
	localparam int BIT_TX_OVERFLOW = 3;
	localparam int BIT_TX_EMPTY = 4;
	localparam int BIT_SLAVE_RESTART = 12;
	localparam int BIT_MASTER_HOLD = 13;

	// Option register bit positions
	localparam int OPT_SLAVE_RESTART = 0;
	localparam int OPT_DYNAMIC_TARGET = 1;
	localparam int OPT_EMPTY_FIFO_HOLD = 2;

	// Threshold field width, depth and reset values
	localparam int THRESHOLD_WIDTH = 8;
	localparam int LEVEL_WIDTH = 9;
	localparam logic [7:0] FIFO_DEPTH_MAX = 8'h0F;
	localparam logic [7:0] RX_THRESHOLD_RESET = 8'h00;
	localparam logic [7:0] TX_THRESHOLD_RESET = 8'h00;
	localparam logic [2:0] OPTIONS_RESET = 3'h0;

	// Events from the bus engine, one-cycle pulses except the master_holding level
	typedef struct packed {
		logic rx_underflow;
		logic rx_overflow;
		logic tx_overflow;
		logic restart_seen;
		logic slave_addressed;
		logic master_holding;
	} isc_event_type;

	// FIFO fill levels from the bus engine
	typedef struct packed {
		logic [8:0] rx_level;
		logic [8:0] tx_level;
	} isc_level_type;

endpackage
`default_nettype wire

/* File: rtl/isc_sticky_flag.sv */
// Sticky interrupt flag with set-wins-over-clear
`timescale 1ns/1ps
`default_nettype none
module isc_sticky_flag
(
	input wire logic clk, // Peripheral clock
	input wire logic rst_n, // Synchronised reset, active low
	input wire logic set_pulse, // Hardware event
	input wire logic clear_pulse, // Software clear
	output logic flag // Sticky flag
);

	logic flag_q;

	// Set wins so an event in the clear cycle is kept
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			flag_q <= 1'b0;
		else if (set_pulse)
			flag_q <= 1'b1;
		else if (clear_pulse)
			flag_q <= 1'b0;
	end

	assign flag = flag_q;

endmodule
`default_nettype wire

/* File: rtl/isc_irq_status.sv */
// Interrupt status, FIFO thresholds and read-to-clear registers over APB
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module isc_irq_status
(
	input wire logic ref_clk, // Peripheral clock, 100 MHz
	input wire logic reset_n, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire isc_pkg::isc_event_type events, // Engine events, same clock
	input wire isc_pkg::isc_level_type levels, // FIFO levels, same clock
	output logic [31:0] raw_status, // Raw status word
	output logic tx_abort_source_clear, // Pulse clearing abort source
	output logic [7:0] rx_threshold_field, // Stored rx threshold
	output logic [7:0] tx_threshold_field // Stored tx threshold
);

	////////////////////////////////////////////////////////////////////
	// Reset synchroniser

	logic rst_meta_q;
	logic rst_sync_q;

	// A raw release could free flops on different edges
	// Release through two flops, assert at once
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Bus decode

	// Register map, byte addresses
	// 0x34 raw status word, read only
	// 0x38 rx threshold, bits 7:0
	// 0x3C tx threshold, bits 7:0
	// 0x40 combined clear, read to clear
	// 0x44 rx underflow clear, read to clear
	// 0x48 rx overflow clear, read to clear
	// 0x4C tx overflow clear, read to clear
	// 0x70 build options, bits 2:0
	// Other addresses raise an error and change nothing

	logic access;
	logic wr_en;
	logic rd_en;
	logic mapped;
	logic sel_rx_thr;
	logic sel_tx_thr;
	logic sel_combined;
	logic sel_rx_under;
	logic sel_rx_over;
	logic sel_tx_over;
	logic sel_status;
	logic sel_options;

	// Zero-wait slave: every access phase completes at once
	assign access = psel && penable;
	assign wr_en = access && pwrite;
	assign rd_en = access && !pwrite;
	assign pready = 1'b1;

	// Address compare used for every register
	function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
		hit = (addr == off);
	endfunction

	// Clamp to buffer depth, used by both thresholds
	function automatic logic [7:0] clamp_depth(input logic [7:0] value);
		clamp_depth = (value > isc_pkg::FIFO_DEPTH_MAX) ? isc_pkg::FIFO_DEPTH_MAX : value;
	endfunction

	// Register selects, decoded once from the address
	assign sel_rx_thr = hit(paddr, isc_pkg::OFF_RX_THRESHOLD);
	assign sel_tx_thr = hit(paddr, isc_pkg::OFF_TX_THRESHOLD);
	assign sel_combined = hit(paddr, isc_pkg::OFF_COMBINED_CLEAR);
	assign sel_rx_under = hit(paddr, isc_pkg::OFF_RX_UNDERFLOW_CLEAR);
	assign sel_rx_over = hit(paddr, isc_pkg::OFF_RX_OVERFLOW_CLEAR);
	assign sel_tx_over = hit(paddr, isc_pkg::OFF_TX_OVERFLOW_CLEAR);
	assign sel_status = hit(paddr, isc_pkg::OFF_RAW_STATUS);
	assign sel_options = hit(paddr, isc_pkg::OFF_OPTIONS);

	// Any select counts as a mapped register
	assign mapped = sel_rx_thr || sel_tx_thr || sel_combined || sel_rx_under
		|| sel_rx_over || sel_tx_over || sel_status || sel_options;

	// Error only in the access phase of an unmapped transfer
	assign pslverr = access && !mapped;

	////////////////////////////////////////////////////////////////////
	// Threshold and option registers

	logic [7:0] rx_threshold_q;
	logic [7:0] tx_threshold_q;
	logic [2:0] options_q;

	// Oversize values store the buffer depth instead
	always_ff @(posedge ref_clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			rx_threshold_q <= isc_pkg::RX_THRESHOLD_RESET;
		else if (wr_en && sel_rx_thr)
			rx_threshold_q <= clamp_depth(pwdata[7:0]);
	end

	// Same clamp on the transmit side
	always_ff @(posedge ref_clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			tx_threshold_q <= isc_pkg::TX_THRESHOLD_RESET;
		else if (wr_en && sel_tx_thr)
			tx_threshold_q <= clamp_depth(pwdata[7:0]);
	end

	// Configuration options, fixed at build time in real parts
	always_ff @(posedge ref_clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			options_q <= isc_pkg::OPTIONS_RESET;
		else if (wr_en && sel_options)
			options_q <= pwdata[2:0];
	end

	// Stored thresholds go straight to the FIFO logic
	assign rx_threshold_field = rx_threshold_q;
	assign tx_threshold_field = tx_threshold_q;

	////////////////////////////////////////////////////////////////////
	// Clear strobes

	logic clr_combined;
	logic clr_rx_under;
	logic clr_rx_over;
	logic clr_tx_over;

	// Limitation: a flag that sets in the setup cycle of its own
	// clear read is cleared unseen; read raw status first where
	// that one-cycle window matters

	// Only reads clear; writes to these addresses do nothing
	assign clr_combined = rd_en && sel_combined;
	assign clr_rx_under = rd_en && sel_rx_under;
	assign clr_rx_over = rd_en && sel_rx_over;
	assign clr_tx_over = rd_en && sel_tx_over;

	// Abort source lives elsewhere; hand it the pulse
	assign tx_abort_source_clear = clr_combined;

	////////////////////////////////////////////////////////////////////
	// Sticky software-clearable flags

	logic rx_underflow_flag;
	logic rx_overflow_flag;
	logic tx_overflow_flag;
	logic slave_restart_flag;
	logic restart_set;
	logic hold_set;
	logic hold_enabled;
	logic master_hold_empty_flag;
	logic restart_enabled;
	logic dyn_target_enabled;
	logic empty_hold_enabled;

	// Option bits, named for the flag logic that reads them
	assign restart_enabled = options_q[isc_pkg::OPT_SLAVE_RESTART];
	assign dyn_target_enabled = options_q[isc_pkg::OPT_DYNAMIC_TARGET];
	assign empty_hold_enabled = options_q[isc_pkg::OPT_EMPTY_FIFO_HOLD];

	// Underflow: own clear register or the combined read
	isc_sticky_flag u_rx_underflow
	(
		.clk(ref_clk),
		.rst_n(rst_sync_q),
		.set_pulse(events.rx_underflow),
		.clear_pulse(clr_rx_under || clr_combined),
		.flag(rx_underflow_flag)
	);

	// Rx overflow: own clear register or the combined read
	isc_sticky_flag u_rx_overflow
	(
		.clk(ref_clk),
		.rst_n(rst_sync_q),
		.set_pulse(events.rx_overflow),
		.clear_pulse(clr_rx_over || clr_combined),
		.flag(rx_overflow_flag)
	);

	// Tx overflow: own clear register or the combined read
	isc_sticky_flag u_tx_overflow
	(
		.clk(ref_clk),
		.rst_n(rst_sync_q),
		.set_pulse(events.tx_overflow),
		.clear_pulse(clr_tx_over || clr_combined),
		.flag(tx_overflow_flag)
	);

	// Restart before address match is ignored: slave not yet addressed
	assign restart_set = events.restart_seen && events.slave_addressed
		&& restart_enabled;

	// Only the combined read clears the restart flag
	isc_sticky_flag u_slave_restart
	(
		.clk(ref_clk),
		.rst_n(rst_sync_q),
		.set_pulse(restart_set),
		.clear_pulse(clr_combined),
		.flag(slave_restart_flag)
	);

	////////////////////////////////////////////////////////////////////
	// Hardware-cleared flags

	// Master hold follows the engine; only valid with both options
	assign hold_enabled = dyn_target_enabled && empty_hold_enabled;
	assign hold_set = events.master_holding && hold_enabled;

	logic hold_q;
	logic rx_full_q;
	logic tx_empty_q;

	// Hold flag follows the engine; a combined read leaves it alone
	always_ff @(posedge ref_clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			hold_q <= 1'b0;
		else
			hold_q <= hold_set;
	end

	// Rx level at or above value plus one entries; no software clear
	always_ff @(posedge ref_clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			rx_full_q <= 1'b0;
		else
			rx_full_q <= levels.rx_level >= ({1'b0, rx_threshold_q} + 9'h001);
	end

	// Tx level at or below value entries; no software clear
	always_ff @(posedge ref_clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			tx_empty_q <= 1'b0;
		else
			tx_empty_q <= levels.tx_level <= {1'b0, tx_threshold_q};
	end

	assign master_hold_empty_flag = hold_q;

	////////////////////////////////////////////////////////////////////
	// Raw status word

	// Status word from the flag flops; unused bits read zero
	always_comb
	begin
		raw_status = 32'h0000_0000;
		raw_status[isc_pkg::BIT_RX_UNDERFLOW] = rx_underflow_flag;
		raw_status[isc_pkg::BIT_RX_OVERFLOW] = rx_overflow_flag;
		raw_status[isc_pkg::BIT_RX_FULL] = rx_full_q;
		raw_status[isc_pkg::BIT_TX_OVERFLOW] = tx_overflow_flag;
		raw_status[isc_pkg::BIT_TX_EMPTY] = tx_empty_q;
		raw_status[isc_pkg::BIT_SLAVE_RESTART] = slave_restart_flag;
		raw_status[isc_pkg::BIT_MASTER_HOLD] = master_hold_empty_flag;
	end

	////////////////////////////////////////////////////////////////////
	// Read data

	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic combined_any;

	// Combined flag is any software-clearable flag set
	assign combined_any = rx_underflow_flag || rx_overflow_flag
		|| tx_overflow_flag || slave_restart_flag;

	// Clear registers return the pre-clear value in bit 0
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		case (paddr)
			isc_pkg::OFF_RX_THRESHOLD: rdata_d[7:0] = rx_threshold_q;
			isc_pkg::OFF_TX_THRESHOLD: rdata_d[7:0] = tx_threshold_q;
			isc_pkg::OFF_COMBINED_CLEAR: rdata_d[0] = combined_any;
			isc_pkg::OFF_RX_UNDERFLOW_CLEAR: rdata_d[0] = rx_underflow_flag;
			isc_pkg::OFF_RX_OVERFLOW_CLEAR: rdata_d[0] = rx_overflow_flag;
			isc_pkg::OFF_TX_OVERFLOW_CLEAR: rdata_d[0] = tx_overflow_flag;
			isc_pkg::OFF_RAW_STATUS: rdata_d = raw_status;
			isc_pkg::OFF_OPTIONS: rdata_d[2:0] = options_q;
			default: rdata_d = 32'h0000_0000;
		endcase
	end

	// Data is registered in the setup cycle, so valid in access phase
	always_ff @(posedge ref_clk or negedge rst_sync_q)
	begin
		if (!rst_sync_q)
			rdata_q <= 32'h0000_0000;
		else if (psel && !penable && !pwrite)
			rdata_q <= rdata_d;
	end

	// Stands from the setup edge until the next read setup
	assign prdata = rdata_q;

endmodule
`default_nettype wire

/* File: verification/isc_irq_status_props.sv */
// Port checker for the interrupt status, threshold and clear block
`timescale 1ns/1ps
`default_nettype none
module isc_irq_status_props
(
	input wire logic ref_clk, // Clock
	input wire logic reset_n, // Reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	input wire logic [31:0] prdata, // APB read data
	input wire logic pready, // APB ready
	input wire logic pslverr, // APB error
	input wire isc_pkg::isc_event_type events, // Engine events
	input wire isc_pkg::isc_level_type levels, // FIFO levels
	input wire logic [31:0] raw_status, // Raw status
	input wire logic tx_abort_source_clear, // Abort source clear
	input wire logic [7:0] rx_threshold_field, // Rx threshold
	input wire logic [7:0] tx_threshold_field // Tx threshold
);
	logic [2:0] rdy_q; // Design is still in reset two edges after release
	////////////////////////////////////////
	// Skip level checks while the release flops settle
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
			rdy_q <= 3'h0;
		else
			rdy_q <= {rdy_q[1:0], 1'b1};
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	sequence s_rd(a);
		psel && penable && !pwrite && paddr == a;
	endsequence
	sequence s_wr(a);
		psel && penable && pwrite && paddr == a;
	endsequence
	////////////////////////////////////////
	a_underflow_clr: assert property (s_rd(isc_pkg::OFF_RX_UNDERFLOW_CLEAR) ##0
		!events.rx_underflow |=> !raw_status[0]) else $error("underflow kept");
	a_overflow_clr: assert property (s_rd(isc_pkg::OFF_RX_OVERFLOW_CLEAR) ##0
		!events.rx_overflow |=> !raw_status[1]) else $error("overflow kept");
	a_tx_ovf_clr: assert property (s_rd(isc_pkg::OFF_TX_OVERFLOW_CLEAR) ##0
		!events.tx_overflow |=> !raw_status[3]) else $error("tx overflow kept");
	a_combined_clr: assert property (s_rd(isc_pkg::OFF_COMBINED_CLEAR) ##0
		events[5:2] == 4'h0 |=> (raw_status & 32'h0000100B) == 32'h0) else $error("not cleared");
	a_abort_pulse: assert property (rdy_q[2] |-> tx_abort_source_clear ==
		(psel && penable && !pwrite && paddr == isc_pkg::OFF_COMBINED_CLEAR)) else $error("abort");
	a_rx_thr_clamp: assert property (s_wr(isc_pkg::OFF_RX_THRESHOLD) |=> rx_threshold_field ==
		(($past(pwdata[7:0]) > isc_pkg::FIFO_DEPTH_MAX) ? isc_pkg::FIFO_DEPTH_MAX : $past(pwdata[7:0])))
		else $error("rx threshold");
	a_tx_thr_clamp: assert property (s_wr(isc_pkg::OFF_TX_THRESHOLD) |=> tx_threshold_field ==
		(($past(pwdata[7:0]) > isc_pkg::FIFO_DEPTH_MAX) ? isc_pkg::FIFO_DEPTH_MAX : $past(pwdata[7:0])))
		else $error("tx threshold");
	a_rx_full_lvl: assert property (rdy_q[2] |-> raw_status[2] == ($past(levels.rx_level) >=
		({1'b0, $past(rx_threshold_field)} + 9'h001))) else $error("rx full");
	a_tx_empty_lvl: assert property (rdy_q[2] |-> raw_status[4] ==
		($past(levels.tx_level) <= {1'b0, $past(tx_threshold_field)})) else $error("tx empty");
	a_restart_cause: assert property ($rose(raw_status[12]) |->
		$past(events.restart_seen) && $past(events.slave_addressed)) else $error("restart");
	a_hold_cause: assert property (raw_status[13] |-> $past(events.master_holding))
		else $error("hold");
	a_clear_upper: assert property (psel && penable && !pwrite && paddr[7:4] == 4'h4
		|-> prdata[31:1] == 31'h0) else $error("upper bits");
endmodule
bind isc_irq_status isc_irq_status_props u_isc_irq_status_props (.ref_clk(ref_clk),
	.reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(events),
	.levels(levels), .raw_status(raw_status), .tx_abort_source_clear(tx_abort_source_clear),
	.rx_threshold_field(rx_threshold_field), .tx_threshold_field(tx_threshold_field));
`default_nettype wire

/* File: verification/isc_irq_status_tb_top.sv */
// Testbench for the interrupt status, threshold and clear block
`timescale 1ns/1ps
`default_nettype none
module isc_irq_status_tb_top;
	logic ref_clk = 1'b0;
	logic reset_n, psel, penable, pwrite, pready, pslverr, tx_abort_source_clear, e;
	logic [7:0] paddr, rx_threshold_field, tx_threshold_field;
	logic [31:0] pwdata, prdata, raw_status, r;
	isc_pkg::isc_event_type events;
	isc_pkg::isc_level_type levels;
	int miscompares = 0;
	int samples_checked = 0;
	int i;
	////////////////////////////////////////
	// Free running 100 MHz clock
	always #5 ref_clk = ~ref_clk;
	isc_irq_status u_isc_irq_status (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .events(events), .levels(levels),
		.raw_status(raw_status), .tx_abort_source_clear(tx_abort_source_clear),
		.rx_threshold_field(rx_threshold_field), .tx_threshold_field(tx_threshold_field));
	////////////////////////////////////////
	// Verdict and end of run
	task automatic end_of_test;
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		samples_checked++;
		if (g !== x)
		begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask
	// One APB transfer plus an idle cycle so level flags settle before the next read
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1)
		begin
			n++;
			if (n > 16)
			begin
				miscompares++;
				end_of_test();
			end
			@(posedge ref_clk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r, x);
	endtask
	task automatic ev(input logic [5:0] v);
		events <= v;
		@(posedge ref_clk);
		events <= 6'h00;
	endtask
	////////////////////////////////////////
	// Main sequence
	initial
	begin
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		events = 6'h00;
		levels = 18'h0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rd(8'h38, 32'h0);
		rd(8'h3C, 32'h0);
		rd(8'h34, 32'h10);
		apb(1'b1, 8'h38, 32'hFFFFFF03);
		rd(8'h38, 32'h3);
		apb(1'b1, 8'h38, 32'hC8);
		rd(8'h38, 32'(isc_pkg::FIFO_DEPTH_MAX));
		apb(1'b1, 8'h38, 32'h3);
		apb(1'b1, 8'h3C, 32'hFF);
		rd(8'h3C, 32'(isc_pkg::FIFO_DEPTH_MAX));
		apb(1'b1, 8'h3C, 32'h5);
		levels <= {9'h003, 9'h005};
		@(posedge ref_clk);
		rd(8'h34, 32'h10);
		levels <= {9'h004, 9'h006};
		@(posedge ref_clk);
		rd(8'h34, 32'h4);
		levels <= {9'h000, 9'h006};
		@(posedge ref_clk);
		for (i = 0; i < 3; i++)
		begin
			ev(6'h20 >> i);
			rd(8'h34, 32'h1 << (i + i / 2));
			apb(1'b1, 8'(8'h44 + 4 * i), 32'hFFFFFFFF);
			rd(8'h34, 32'h1 << (i + i / 2));
			rd(8'(8'h44 + 4 * i), 32'h1);
			rd(8'h34, 32'h0);
			rd(8'(8'h44 + 4 * i), 32'h0);
		end
		apb(1'b1, 8'h70, 32'h1);
		ev(6'h04);
		rd(8'h34, 32'h0);
		ev(6'h06);
		rd(8'h34, 32'h1000);
		levels <= {9'h004, 9'h006};
		ev(6'h38);
		rd(8'h34, 32'h100F);
		rd(8'h40, 32'h1);
		rd(8'h34, 32'h4);
		rd(8'h40, 32'h0);
		events <= 6'h01;
		apb(1'b1, 8'h70, 32'h2);
		rd(8'h34, 32'h4);
		apb(1'b1, 8'h70, 32'h6);
		rd(8'h34, 32'h2004);
		events <= 6'h00;
		rd(8'h20, 32'h0);
		chk({31'h0, e}, 32'h1);
		end_of_test();
	end
endmodule
`default_nettype wire
